// ===== core/serial_port_pkg.sv
// Constants, field positions and state types of the serial port
package serial_port_pkg;

   // ----------------------------------------------------------------
   // Register locations and reset value
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR  = 8'h98;
   localparam logic [7:0] DATA_ADDR  = 8'h99;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   localparam logic [7:0] READ_NONE  = 8'h00;

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int MODE_BIT = 7;
   localparam int FILL_BIT = 6;
   localparam int MPE_BIT  = 5;
   localparam int REN_BIT  = 4;
   localparam int TN_BIT   = 3;
   localparam int RN_BIT   = 2;
   localparam int TD_BIT   = 1;
   localparam int RD_BIT   = 0;

   // ----------------------------------------------------------------
   // Frame and counter figures
   // ----------------------------------------------------------------
   localparam logic [3:0] TX_BITS_8 = 4'hA;
   localparam logic [3:0] TX_BITS_9 = 4'hB;
   localparam logic [3:0] DATA_LAST = 4'h7;
   localparam logic [3:0] NINTH_IDX = 4'h8;
   localparam logic [3:0] CNT_ONE   = 4'h1;
   localparam logic [7:0] TMR_TOP   = 8'hFF;
   localparam logic [7:0] TMR_STEP  = 8'h01;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
   typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

endpackage : serial_port_pkg

// ===== core/baud_counter.sv
// Eight-bit auto-reload baud counter with divide-by-two tick
`timescale 1ns/1ps
module baud_counter
   import serial_port_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       timer_tick,
   input  wire logic       timer_run,
   input  wire logic [7:0] reload,
   input  wire logic       force_reload,
   output logic            baud_tick
);

   typedef struct packed {
      logic [7:0] count;
      logic       half;
      logic       tick;
   } cnt_s;

   cnt_s s;
   cnt_s next_s;

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      if (force_reload) begin
         // Restart phase too, so the first tick lands half a bit later
         next_s.count = reload;
         next_s.half  = 1'b0;
      end else if (timer_run && timer_tick) begin
         if (s.count == TMR_TOP) begin
            next_s.count = reload;
            next_s.tick  = ~s.half;
            next_s.half  = ~s.half;
         end else begin
            next_s.count = s.count + TMR_STEP;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign baud_tick = s.tick;

endmodule : baud_counter

// ===== core/tx_shifter.sv
// Transmit shift register for ten- and eleven-bit frames
`timescale 1ns/1ps
module tx_shifter
   import serial_port_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       tick,
   input  wire logic       start,
   input  wire logic [7:0] data,
   input  wire logic       ninth,
   input  wire logic       nine_mode,
   output logic            tx_line,
   output logic            done
);

   typedef struct packed {
      tx_state_e   st;
      logic [10:0] shift;
      logic [3:0]  left;
      logic        line;
      logic        done;
   } tx_s;

   tx_s s;
   tx_s next_s;

   // ----------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------
   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      case (s.st)
         TX_IDLE: begin
            // Writes while busy are dropped; software waits for done
            if (start) begin
               next_s.st    = TX_SEND;
               next_s.shift = {1'b1, nine_mode ? ninth : 1'b1, data, 1'b0};
               next_s.left  = nine_mode ? TX_BITS_9 : TX_BITS_8;
            end
         end
         default: begin
            if (tick) begin
               if (s.left == '0) begin
                  next_s.st = TX_IDLE;
               end else begin
                  next_s.line  = s.shift[0];
                  next_s.shift = {1'b1, s.shift[10:1]};
                  next_s.left  = s.left - CNT_ONE;
                  next_s.done  = (s.left == CNT_ONE);
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s      <= '0;
         s.line <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign tx_line = s.line;
   assign done    = s.done;

endmodule : tx_shifter

// ===== core/serial_port.sv
// Buffered asynchronous serial port top level
// Functional notes
// - Full duplex, ten- or eleven-bit variable-rate frames
// - Receiver holds byte while next arrives
// - Data location writes go to transmitter
// - Data location reads return received byte
// - Interrupt when enabled and either flag set
// - Flags clear only by software write
// - Tx and hidden rx auto-reload counters
// - Both overflow streams divided by two
// - Rate is clock over 256-reload, halved
// - Rx counter runs with timer, same reload
// - Start edge forces rx counter reload
// - Control bit 7 selects frame mode
// - Ten-bit frame: start, eight LSB-first, stop
// - Eight-bit mode: stop bit into ninth flag
// - Data write starts; done at stop start
// - Receive only when enable bit set
// - Load needs done clear, stop if eight-bit multiprocessor
// - Load stores data, bit, sets done
// - Overrun keeps first byte, drops next
// - Eleven-bit frame carries ninth transmit bit
// - Nine-bit mode: ninth bit stored, stop ignored
// - Multiprocessor nine-bit: load only ninth one
`timescale 1ns/1ps
module serial_port
   import serial_port_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       timer_tick,
   input  wire logic       timer_run,
   input  wire logic [7:0] baud_timer_reload_byte,
   input  wire logic       irq_enable,
   input  wire logic       serial_rx_pin,
   output logic            serial_tx_pin,
   output logic            irq_request
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       frame_mode_select;
      logic       multiprocessor_enable;
      logic       receive_enable_bit;
      logic       transmit_ninth_bit;
      logic       received_ninth_bit;
      logic       transmit_done_flag;
      logic       receive_done_flag;
      logic [7:0] rbuf;
      rx_state_e  rst;
      logic [7:0] rdat;
      logic       nth;
      logic [3:0] rcnt;
      logic       prev_rx;
      logic [7:0] rdata;
      logic       irq;
   } port_s;

   port_s s;
   port_s next_s;

   logic       ctrl_wr;
   logic       data_wr;
   logic       start_seen;
   logic       tx_tick;
   logic       rx_tick;
   logic       tx_done;
   logic       stop_bit;
   logic       load_bit;
   logic       rx_load;
   logic       tx_line;
   logic [7:0] ctrl_view;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_wr = 1'b0;
      data_wr = 1'b0;
      if (sfr_wr && sfr_addr == CTRL_ADDR) begin
         ctrl_wr = 1'b1;
      end else if (sfr_wr && sfr_addr == DATA_ADDR) begin
         data_wr = 1'b1;
      end
   end

   // Falling edge on an idle line opens a frame
   assign start_seen = (s.rst == RX_IDLE) && s.receive_enable_bit
                       && s.prev_rx && !serial_rx_pin;

   assign stop_bit = serial_rx_pin;
   assign load_bit = s.frame_mode_select ? s.nth : stop_bit;
   assign rx_load  = (s.rst == RX_STOP) && rx_tick && !s.receive_done_flag
                     && (!s.multiprocessor_enable || load_bit);

   // ----------------------------------------------------------------
   // Baud counters and transmitter
   // ----------------------------------------------------------------
   baud_counter tx_timer (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .timer_tick   (timer_tick),
      .timer_run    (timer_run),
      .reload       (baud_timer_reload_byte),
      .force_reload (1'b0),
      .baud_tick    (tx_tick)
   );

   baud_counter rx_timer (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .timer_tick   (timer_tick),
      .timer_run    (timer_run),
      .reload       (baud_timer_reload_byte),
      .force_reload (start_seen),
      .baud_tick    (rx_tick)
   );

   tx_shifter shifter (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .tick      (tx_tick),
      .start     (data_wr),
      .data      (sfr_wdata),
      .ninth     (s.transmit_ninth_bit),
      .nine_mode (s.frame_mode_select),
      .tx_line   (tx_line),
      .done      (tx_done)
   );

   assign serial_tx_pin = tx_line;

   // ----------------------------------------------------------------
   // Control register view
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_view           = READ_NONE;
      ctrl_view[MODE_BIT] = s.frame_mode_select;
      ctrl_view[FILL_BIT] = 1'b1;
      ctrl_view[MPE_BIT]  = s.multiprocessor_enable;
      ctrl_view[REN_BIT]  = s.receive_enable_bit;
      ctrl_view[TN_BIT]   = s.transmit_ninth_bit;
      ctrl_view[RN_BIT]   = s.received_ninth_bit;
      ctrl_view[TD_BIT]   = s.transmit_done_flag;
      ctrl_view[RD_BIT]   = s.receive_done_flag;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s         = s;
      next_s.prev_rx = serial_rx_pin;

      if (ctrl_wr) begin
         next_s.frame_mode_select     = sfr_wdata[MODE_BIT];
         next_s.multiprocessor_enable = sfr_wdata[MPE_BIT];
         next_s.receive_enable_bit    = sfr_wdata[REN_BIT];
         next_s.transmit_ninth_bit    = sfr_wdata[TN_BIT];
         next_s.received_ninth_bit    = sfr_wdata[RN_BIT];
         next_s.transmit_done_flag    = sfr_wdata[TD_BIT];
         next_s.receive_done_flag     = sfr_wdata[RD_BIT];
      end

      // Hardware sets override a clear written in the same cycle
      if (tx_done) begin
         next_s.transmit_done_flag = 1'b1;
      end

      // Receiver: separate shift bytes keep the buffer readable
      case (s.rst)
         RX_IDLE: begin
            if (start_seen) begin
               next_s.rst = RX_START;
            end
         end
         RX_START: begin
            if (rx_tick) begin
               // Glitch shorter than half a bit is not a start
               if (serial_rx_pin) begin
                  next_s.rst = RX_IDLE;
               end else begin
                  next_s.rst  = RX_DATA;
                  next_s.rcnt = '0;
               end
            end
         end
         RX_DATA: begin
            if (rx_tick) begin
               if (s.rcnt < NINTH_IDX) begin
                  next_s.rdat[s.rcnt[2:0]] = serial_rx_pin;
               end else begin
                  next_s.nth = serial_rx_pin;
               end
               if (s.rcnt == (s.frame_mode_select ? NINTH_IDX : DATA_LAST)) begin
                  next_s.rst = RX_STOP;
               end else begin
                  next_s.rcnt = s.rcnt + CNT_ONE;
               end
            end
         end
         default: begin
            if (rx_tick) begin
               next_s.rst = RX_IDLE;
            end
         end
      endcase

      // Overrun leaves buffer, ninth bit and flag as they were
      if (rx_load) begin
         next_s.rbuf               = s.rdat;
         next_s.received_ninth_bit = load_bit;
         next_s.receive_done_flag  = 1'b1;
      end

      if (sfr_rd) begin
         if (sfr_addr == CTRL_ADDR) begin
            next_s.rdata = ctrl_view;
         end else if (sfr_addr == DATA_ADDR) begin
            next_s.rdata = s.rbuf;
         end else begin
            next_s.rdata = READ_NONE;
         end
      end

      next_s.irq = irq_enable && (s.transmit_done_flag || s.receive_done_flag);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s                       <= '0;
         s.frame_mode_select     <= CTRL_RESET[MODE_BIT];
         s.multiprocessor_enable <= CTRL_RESET[MPE_BIT];
         s.receive_enable_bit    <= CTRL_RESET[REN_BIT];
         s.prev_rx               <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign sfr_rdata   = s.rdata;
   assign irq_request = s.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   sequence stop_sample;
      s.rst == RX_STOP && rx_tick;
   endsequence

   sequence frame_open;
      start_seen ##1 s.rst == RX_START;
   endsequence

   chk_data_write_tx: assert property (
      data_wr && !rx_load |=> $stable(s.rbuf))
      else $error("data write disturbed receive buffer");

   chk_data_read_rx: assert property (
      sfr_rd && sfr_addr == DATA_ADDR |=> sfr_rdata == $past(s.rbuf))
      else $error("data read did not return receive buffer");

   chk_irq_follow: assert property (
      irq_enable && (s.transmit_done_flag || s.receive_done_flag) |=> irq_request)
      else $error("interrupt not raised");

   chk_flag_sticky: assert property (
      s.receive_done_flag && !ctrl_wr |=> s.receive_done_flag)
      else $error("receive done cleared without write");

   chk_tx_done_stop: assert property (
      tx_done |=> serial_tx_pin && s.transmit_done_flag)
      else $error("transmit done not at stop bit");

   chk_rx_enable_gate: assert property (
      s.rst == RX_IDLE && !s.receive_enable_bit |=> s.rst == RX_IDLE)
      else $error("receiver left idle while disabled");

   chk_overrun_keep: assert property (
      s.receive_done_flag ##0 stop_sample |=> $stable(s.rbuf))
      else $error("overrun overwrote buffer");

   chk_mpe_filter: assert property (
      stop_sample ##0 (!s.receive_done_flag && s.multiprocessor_enable
                       && !load_bit && !ctrl_wr) |=> !s.receive_done_flag)
      else $error("frame loaded despite multiprocessor filter");

   chk_start_reject: assert property (
      s.rst == RX_START && rx_tick && serial_rx_pin |=> s.rst == RX_IDLE)
      else $error("false start not rejected");

   chk_start_reload: assert property (
      frame_open |-> !rx_tick)
      else $error("rx tick right after forced reload");

endmodule : serial_port

// ===== bench/far_uart.sv
// Far-side serial port model: frame sender and line monitor
`timescale 1ns/1ps
module far_uart (
   input  wire logic       core_clk,
   input  wire logic [7:0] reload,
   input  wire logic       nine_mode,
   input  wire logic       serial_tx_pin,
   output logic            serial_rx_pin
);
   int         bit_cyc;
   int         cap_count;
   logic [7:0] cap_data;
   logic       cap_ninth;
   logic       cap_stop;

   // Timer clocked every cycle, so one bit is two overflows
   assign bit_cyc = (256 - int'(reload)) * 2;

   initial begin
      serial_rx_pin = 1'b1;
      cap_count     = 0;
   end

   // Called just after a rising edge; holds each bit whole
   task automatic bit_out(input logic b);
      serial_rx_pin <= b;
      repeat (bit_cyc) @(posedge core_clk);
   endtask : bit_out

   task automatic send_frame(input logic [7:0] v, input logic nb, input logic stop);
      bit_out(1'b0);
      for (int i = 0; i < 8; i++) bit_out(v[i]);
      if (nine_mode) bit_out(nb);
      bit_out(stop);
      serial_rx_pin <= 1'b1;
   endtask : send_frame

   // Too short to survive the mid-start sample
   task automatic short_low();
      serial_rx_pin <= 1'b0;
      repeat (2) @(posedge core_clk);
      serial_rx_pin <= 1'b1;
   endtask : short_low

   initial forever begin
      @(negedge serial_tx_pin);
      repeat (bit_cyc / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge core_clk);
         cap_data[i] = serial_tx_pin;
      end
      if (nine_mode) begin
         repeat (bit_cyc) @(posedge core_clk);
         cap_ninth = serial_tx_pin;
      end
      repeat (bit_cyc) @(posedge core_clk);
      cap_stop  = serial_tx_pin;
      cap_count = cap_count + 1;
   end
endmodule : far_uart

// ===== bench/serial_port_bench.sv
// Self-checking bench for the buffered serial port
`timescale 1ns/1ps
module serial_port_bench
   import serial_port_pkg::*;
;
   logic       core_clk;
   logic       nrst;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic       timer_tick;
   logic       timer_run;
   logic [7:0] baud_timer_reload_byte;
   logic       irq_enable;
   logic       serial_rx_pin;
   logic       serial_tx_pin;
   logic       irq_request;
   logic       nine;
   logic [7:0] rd;
   logic [7:0] d;
   logic [7:0] x;
   logic       nb;
   int         n;
   int         bad_count;
   int         total_checks;

   serial_port i_dut (.core_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .timer_tick, .timer_run, .baud_timer_reload_byte, .irq_enable,
      .serial_rx_pin, .serial_tx_pin, .irq_request);

   far_uart i_far (.core_clk, .reload(baud_timer_reload_byte), .nine_mode(nine),
      .serial_tx_pin, .serial_rx_pin);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      sfr_addr  <= a;
      sfr_wdata <= v;
      sfr_wr    <= 1'b1;
      @(posedge core_clk);
      sfr_wr    <= 1'b0;
      @(posedge core_clk);
   endtask : reg_write

   // Read data is registered and holds, so sampling at the next edge is safe
   task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(posedge core_clk);
      sfr_rd   <= 1'b0;
      @(posedge core_clk);
      v = sfr_rdata;
   endtask : reg_read

   task automatic wait_capture(input int n0);
      for (int i = 0; i < 400; i++) begin
         @(posedge core_clk);
         if (i_far.cap_count != n0) return;
      end
      check(9'h000, 9'h001, "no frame on line");
      print_verdict();
   endtask : wait_capture

   // Load decision from enable, overrun and multiprocessor filter
   function automatic logic rx_loads(input logic [7:0] c, input logic nb,
                                     input logic stop);
      logic key;
      key = c[MODE_BIT] ? nb : stop;
      return c[REN_BIT] && !c[RD_BIT] && (!c[MPE_BIT] || key);
   endfunction : rx_loads

   // Control write loads both flags from c before the frame arrives
   task automatic rx_case(input logic [7:0] c, input logic nb, input logic stop);
      logic [7:0] v;
      logic [7:0] old;
      logic [7:0] ctl;
      logic       load;
      v    = 8'($urandom);
      load = rx_loads(c, nb, stop);
      reg_read(DATA_ADDR, old);
      reg_write(CTRL_ADDR, c);
      nine <= c[MODE_BIT];
      i_far.send_frame(v, nb, stop);
      repeat (4) @(posedge core_clk);
      reg_read(CTRL_ADDR, ctl);
      check(ctl[RD_BIT], load | c[RD_BIT], "rx done");
      check(ctl[RN_BIT], load ? (c[MODE_BIT] ? nb : stop) : c[RN_BIT], "ninth");
      reg_read(DATA_ADDR, ctl);
      check(ctl, load ? v : old, "rx data");
   endtask : rx_case

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      nrst                   = 1'b0;
      sfr_addr               = 8'h00;
      sfr_wr                 = 1'b0;
      sfr_rd                 = 1'b0;
      sfr_wdata              = 8'h00;
      timer_tick             = 1'b1;
      timer_run              = 1'b1;
      baud_timer_reload_byte = 8'hFA;
      irq_enable             = 1'b1;
      nine                   = 1'b0;
      bad_count              = 0;
      total_checks           = 0;
      void'($urandom(85));
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      reg_read(CTRL_ADDR, rd);
      check(rd, CTRL_RESET, "control reset");
      reg_read(8'h55, rd);
      check(rd, READ_NONE, "unmapped read");
      // Both frame modes at two rates
      for (int k = 0; k < 4; k++) begin
         d  = 8'($urandom);
         nb = 1'($urandom);
         nine <= k[0];
         baud_timer_reload_byte <= k[1] ? 8'hF6 : 8'hFA;
         reg_write(CTRL_ADDR, {k[0], 3'b000, nb, 3'b000});
         n = i_far.cap_count;
         reg_write(DATA_ADDR, d);
         wait_capture(n);
         reg_read(CTRL_ADDR, rd);
         check(rd[TD_BIT], 1'b1, "done by mid stop");
         check(irq_request, 1'b1, "irq on done");
         check(i_far.cap_data, d, "tx data");
         check(i_far.cap_stop, 1'b1, "tx stop");
         if (k[0]) check(i_far.cap_ninth, nb, "tx ninth");
         repeat (40) @(posedge core_clk);
         reg_read(CTRL_ADDR, rd);
         check(rd[TD_BIT], 1'b1, "flag kept");
         reg_write(CTRL_ADDR, {k[0], 3'b000, nb, 3'b000});
         reg_read(CTRL_ADDR, rd);
         check(rd[TD_BIT], 1'b0, "flag cleared");
         check(irq_request, 1'b0, "irq dropped");
      end
      baud_timer_reload_byte <= 8'hFA;
      rx_case(8'h00, 1'b0, 1'b1);
      rx_case(8'h10, 1'b0, 1'b1);
      rx_case(8'h11, 1'b0, 1'b1);
      rx_case(8'h34, 1'b0, 1'b0);
      rx_case(8'h30, 1'b0, 1'b1);
      rx_case(8'h14, 1'b0, 1'b0);
      rx_case(8'hB4, 1'b0, 1'b1);
      rx_case(8'hB0, 1'b1, 1'b0);
      rx_case(8'h94, 1'b0, 1'b1);
      // Runt low pulse must not start a frame
      reg_write(CTRL_ADDR, 8'h10);
      nine <= 1'b0;
      i_far.short_low();
      repeat (40) @(posedge core_clk);
      reg_read(CTRL_ADDR, rd);
      check(rd[RD_BIT], 1'b0, "runt start");
      // Full duplex with the receive frame at a random phase
      x = 8'($urandom);
      d = 8'($urandom);
      n = i_far.cap_count;
      reg_write(DATA_ADDR, x);
      repeat ($urandom_range(9)) @(posedge core_clk);
      i_far.send_frame(d, 1'b0, 1'b1);
      repeat (4) @(posedge core_clk);
      wait_capture(n);
      check(i_far.cap_data, x, "duplex tx");
      reg_read(DATA_ADDR, rd);
      check(rd, d, "duplex rx");
      // Both flags are set here, so only the enable gates the request
      irq_enable <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(irq_request, 1'b0, "irq masked");
      irq_enable <= 1'b1;
      repeat (2) @(posedge core_clk);
      check(irq_request, 1'b1, "irq unmasked");
      // Stopped timer holds a queued frame until it runs again
      repeat (20) @(posedge core_clk);
      timer_run <= 1'b0;
      n = i_far.cap_count;
      reg_write(DATA_ADDR, d);
      repeat (100) @(posedge core_clk);
      check(serial_tx_pin, 1'b1, "line idle with timer stopped");
      check(9'(i_far.cap_count - n), 9'h000, "frame with timer stopped");
      timer_run <= 1'b1;
      wait_capture(n);
      check(i_far.cap_data, d, "frame after timer restart");
      print_verdict();
   end
endmodule : serial_port_bench
